// *** hdl/supply_monitor_pkg.sv ***
// constants and types shared by the supply monitor design
package supply_monitor_pkg;
  // register index and its byte address on the 32-bit bus
  localparam logic [7:0] CTRL_IDX = 8'h11;
  localparam logic [7:0] CTRL_ADDR = 8'(CTRL_IDX << 2);
  // field positions
  localparam int THR_LSB = 0;
  localparam int THR_W = 4;
  localparam int RANGE_BIT = 4;
  localparam int GOOD_BIT = 5;
  // values after reset
  localparam logic [3:0] THR_RST = 4'h2;
  localparam logic RANGE_RST = 1'b0;
  localparam logic GOOD_RST = 1'b0;
  // threshold map in millivolts: 1700, 50, 2550, 75
  localparam int MV_W = 12;
  localparam logic [11:0] LOW_BASE_MV = 12'h6A4;
  localparam logic [11:0] LOW_STEP_MV = 12'h032;
  localparam logic [11:0] HIGH_BASE_MV = 12'h9F6;
  localparam logic [11:0] HIGH_STEP_MV = 12'h04B;
  // comparator settling after enable or threshold change
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
  typedef enum logic [1:0] {
    MON_OFF,
    MON_SETTLE,
    MON_RUN
  } mon_state_t;
endpackage

// *** hdl/threshold_if.sv ***
// threshold code and its millivolt value between monitor parts
`timescale 1ns/1ps
`default_nettype none
interface threshold_if;
  logic [3:0] code;
  logic range;
  logic [11:0] mv;
  modport mapper (input code, input range, output mv);
  modport owner (output code, output range, input mv);
endinterface
`default_nettype wire

// *** hdl/level_sync.sv ***
// two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_chk
    $error("level_sync needs WIDTH of at least one");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// *** hdl/threshold_mapper.sv ***
// maps the threshold code and range onto a millivolt level
`timescale 1ns/1ps
`default_nettype none
module threshold_mapper
  import supply_monitor_pkg::*;
#(
  parameter int OUT_W = MV_W
) (
  // threshold carrier
  threshold_if.mapper thr
);
  logic [11:0] step_mv;

  if (OUT_W != 12) begin : g_chk
    $error("threshold_mapper supports a 12-bit millivolt output only");
  end

  always_comb begin
    step_mv = thr.range ? HIGH_STEP_MV : LOW_STEP_MV;
    if (thr.range) begin
      thr.mv = 12'(HIGH_BASE_MV + 12'(step_mv * {8'h00, thr.code}));
    end else begin
      thr.mv = 12'(LOW_BASE_MV + 12'(step_mv * {8'h00, thr.code}));
    end
  end
endmodule
`default_nettype wire

// *** hdl/supply_voltage_monitor.sv ***
// supply voltage monitor with its control register on wishbone
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_monitor
  import supply_monitor_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // transceiver state
  input wire logic power_on_state_i,
  input wire logic sleep_state_i,
  input wire logic state_a_i,
  // analog comparator
  input wire logic supply_above_i,
  output logic comparator_enable_o,
  output logic [11:0] threshold_mv_o,
  // event to the interrupt controller
  output logic low_supply_interrupt_o
);

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [3:0] thr_q;
  logic [3:0] thr_d;
  logic range_q;
  logic range_d;
  logic req;
  logic hit;
  logic wr_en;
  logic rd_en;

  mon_state_t state_q;
  mon_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic good_q;
  logic good_d;
  logic irq_q;
  logic irq_d;
  logic en_q;
  logic en_d;
  logic [11:0] mv_q;
  logic ever_good_q;
  logic ever_good_d;
  logic active;
  logic above_s;

  threshold_if thr_bus ();

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CNT_W)) begin : g_chk
    $error("settle count does not fit its counter");
  end

  //////////////////////////////////////////////////////////////////////////
  // comparator input and threshold mapping

  level_sync #(
    .WIDTH(1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(supply_above_i),
    .sync_o(above_s)
  );

  assign thr_bus.code = thr_q;
  assign thr_bus.range = range_q;

  threshold_mapper #(
    .OUT_W(MV_W)
  ) u_map (
    .thr(thr_bus.mapper)
  );

  //////////////////////////////////////////////////////////////////////////
  // wishbone register access

  assign req = cyc_i & stb_i & ~ack_q;
  assign hit = (adr_i == CTRL_ADDR);
  assign wr_en = req & we_i & hit & sel_i[0];
  assign rd_en = req & ~we_i & hit;

  always_comb begin
    ack_d = req;
    thr_d = thr_q;
    range_d = range_q;
    dat_d = 32'h0000_0000;
    if (wr_en) begin
      thr_d = dat_i[THR_LSB +: THR_W];
      range_d = dat_i[RANGE_BIT];
    end
    if (rd_en) begin
      dat_d[THR_LSB +: THR_W] = thr_q;
      dat_d[RANGE_BIT] = range_q;
      dat_d[GOOD_BIT] = good_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      thr_q <= THR_RST;
      range_q <= RANGE_RST;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      thr_q <= thr_d;
      range_q <= range_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // monitor sequencing and flag

  assign active = ~(power_on_state_i | sleep_state_i | state_a_i);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    good_d = good_q;
    irq_d = 1'b0;
    en_d = en_q;
    ever_good_d = ever_good_q | good_q;
    case (state_q)
      MON_OFF: begin
        if (active) begin
          state_d = MON_SETTLE;
          cnt_d = CNT_W'(SETTLE_CYCLES);
          en_d = 1'b1;
        end
      end
      MON_SETTLE: begin
        if (!active) begin
          state_d = MON_OFF;
          en_d = 1'b0;
        end else if (wr_en) begin
          cnt_d = CNT_W'(SETTLE_CYCLES);
        end else if (cnt_q == '0) begin
          state_d = MON_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      MON_RUN: begin
        if (!active) begin
          state_d = MON_OFF;
          en_d = 1'b0;
        end else if (wr_en) begin
          state_d = MON_SETTLE;
          cnt_d = CNT_W'(SETTLE_CYCLES);
        end else begin
          good_d = above_s;
          irq_d = good_q & ~above_s;
        end
      end
      default: begin
        state_d = MON_OFF;
        en_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= MON_OFF;
      cnt_q <= '0;
      good_q <= GOOD_RST;
      irq_q <= 1'b0;
      en_q <= 1'b0;
      mv_q <= 12'h000;
      ever_good_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      good_q <= good_d;
      irq_q <= irq_d;
      en_q <= en_d;
      mv_q <= thr_bus.mv;
      ever_good_q <= ever_good_d;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign comparator_enable_o = en_q;
  assign threshold_mv_o = mv_q;
  assign low_supply_interrupt_o = irq_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  supply_drop_a: assert property (
    state_q == MON_RUN && active && !wr_en && good_q && !above_s
    |=> !good_q && irq_q)
    else $error("supply drop did not clear flag and raise event");

  high_map_a: assert property (
    range_q |=> mv_q == 12'(HIGH_BASE_MV
      + 12'(HIGH_STEP_MV * {8'h00, $past(thr_q)})))
    else $error("high range threshold level wrong");

  low_map_a: assert property (
    !range_q |=> mv_q == 12'(LOW_BASE_MV
      + 12'(LOW_STEP_MV * {8'h00, $past(thr_q)})))
    else $error("low range threshold level wrong");

  range_write_a: assert property (
    wr_en |=> range_q == $past(dat_i[RANGE_BIT]) && ack_o)
    else $error("range select write not stored");

  flag_read_a: assert property (
    rd_en |=> ack_o && dat_o[GOOD_BIT] == $past(good_q))
    else $error("flag read back wrong");

  thr_write_a: assert property (
    wr_en |=> thr_q == $past(dat_i[THR_LSB +: THR_W]))
    else $error("threshold write not stored");

  idle_hold_a: assert property (
    !active |=> !comparator_enable_o && state_q == MON_OFF)
    else $error("monitor active in an idle state");

  flag_freeze_a: assert property (
    !active |=> $stable(good_q))
    else $error("flag changed in an idle state");

  event_edge_a: assert property (
    irq_q |-> $past(good_q) && !good_q ##1 !irq_q)
    else $error("event without a falling flag");

  never_good_a: assert property (
    !ever_good_q |-> !irq_q)
    else $error("event while flag was never one");

  thr_noevent_a: assert property (
    wr_en && !good_q |=> !irq_q [*2])
    else $error("event after threshold write with low flag");

  reserved_zero_a: assert property (
    rd_en |=> dat_o[7:6] == 2'b00 && dat_o[31:8] == 24'h000000)
    else $error("reserved bits read non-zero");

  wake_enable_a: assert property (
    state_q == MON_OFF && active |=> comparator_enable_o
      && state_q == MON_SETTLE)
    else $error("comparator not enabled on wake-up");

  settle_end_a: assert property (
    state_q == MON_SETTLE && active && !wr_en && cnt_q == '0
    |=> state_q == MON_RUN)
    else $error("settle wait did not end in compare");

  settle_freeze_a: assert property (
    state_q == MON_SETTLE |=> $stable(good_q) && !irq_q)
    else $error("flag or event changed during settle");

  idle_noevent_a: assert property (
    !active |=> !irq_q)
    else $error("event raised in an idle state");

  fall_event_a: assert property (
    $fell(good_q) |-> irq_q)
    else $error("flag fell without an event");

  stray_write_a: assert property (
    req && we_i && !(hit && sel_i[0]) |=> $stable(thr_q) && $stable(range_q))
    else $error("ignored write changed the register");

  flag_follow_a: assert property (
    state_q == MON_RUN && active && !wr_en |=> good_q == $past(above_s))
    else $error("flag does not follow the comparator");

  idle_data_a: assert property (
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside an acknowledge");

endmodule
`default_nettype wire

// *** testbench/supply_voltage_monitor_bench.sv ***
// self-checking bench for the supply voltage monitor
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_monitor_bench;
  import supply_monitor_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic [31:0] d;
  logic ack_o;
  logic pon_i = 0;
  logic slp_i = 0;
  logic sa_i = 0;
  logic above_i = 0;
  logic en_o;
  logic irq_o;
  logic [11:0] mv_o;
  int err_total = 0;
  int checked = 0;
  int irqs = 0;
  int n = 0;
  int supply_mv = 0;
  int seed = 32'h89F5;

  always #25 clk_i = ~clk_i;

  // counts every cycle the event output is high
  always @(posedge clk_i) begin
    if (irq_o === 1'b1) irqs <= irqs + 1;
  end

  supply_voltage_monitor dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .power_on_state_i(pon_i), .sleep_state_i(slp_i), .state_a_i(sa_i),
    .supply_above_i(above_i), .comparator_enable_o(en_o),
    .threshold_mv_o(mv_o), .low_supply_interrupt_o(irq_o));

  //////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one classic cycle; read data lands in rd at the ack edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= wd;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 100);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    if (k >= 100) chk(0, 1);
  endtask

  // two sync stages plus the comparator settle wait, with margin
  task automatic settle();
    repeat (30) @(posedge clk_i);
  endtask

  function automatic logic [11:0] exp_mv(input int i);
    return 12'(i[4] ? 2550 + 75 * (i % 16) : 1700 + 50 * (i % 16));
  endfunction

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    bus(1, 8'h48, 32'h1F);
    bus(0, 8'h48, 0);
    chk(rd, 0);
    bus(0, CTRL_ADDR, 0);
    chk(rd, 32'h02);
    chk(mv_o, exp_mv(2));
    for (int i = 0; i < 32; i++) begin
      d = $random(seed);
      bus(1, CTRL_ADDR, {d[31:5], 5'(i)});
      bus(0, CTRL_ADDR, 0);
      chk(rd, i);
      chk(mv_o, exp_mv(i));
    end
    chk(irqs, 0);
    bus(1, CTRL_ADDR, 32'hE2);
    for (int i = 0; i < 3; i++) begin
      {pon_i, slp_i, sa_i} <= 3'b000;
      above_i <= 1;
      settle();
      bus(0, CTRL_ADDR, 0);
      chk(rd, 32'h22);
      chk(irqs, n);
      {pon_i, slp_i, sa_i} <= 3'(1 << i);
      repeat (3) @(posedge clk_i);
      chk(en_o, 0);
      above_i <= 0;
      settle();
      bus(0, CTRL_ADDR, 0);
      chk(rd, 32'h22);
      chk(irqs, n);
      {pon_i, slp_i, sa_i} <= 3'b000;
      settle();
      chk(en_o, 1);
      bus(0, CTRL_ADDR, 0);
      chk(rd, 32'h02);
      n++;
      chk(irqs, n);
    end
    above_i <= 1;
    settle();
    above_i <= 0;
    settle();
    bus(0, CTRL_ADDR, 0);
    chk(rd, 32'h02);
    chk(irqs, n + 1);
    // host lowers the threshold under a supply that wanders round 1.80 V
    bus(1, CTRL_ADDR, 32'h00);
    supply_mv = 1750 + ({$random(seed)} % 100);
    above_i <= supply_mv > exp_mv(0);
    settle();
    bus(0, CTRL_ADDR, 0);
    chk(rd, 32'h20);
    for (int i = 0; i < 20; i++) begin
      supply_mv = 1750 + ({$random(seed)} % 100);
      above_i <= supply_mv > exp_mv(0);
      repeat (3) @(posedge clk_i);
    end
    settle();
    chk(irqs, n + 1);
    bus(0, CTRL_ADDR, 0);
    chk(rd, 32'h20);
    report_and_stop();
  end

  initial begin
    #500000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
